// ### design/lkw_entry_decode.sv
// decodes the staged fields into table entry attributes
`timescale 1ns/1ps
`default_nettype none
module lkw_entry_decode
  import lkw_pkg::*;
(
  // staged words
  input wire lkw_upper_type upper_i,
  input wire logic [31:0] lower_i,
  // global destination-highest-priority setting
  input wire logic da_prio_i,
  // decoded entry
  output lkw_entry_type entry_o
);

  // port field to port mask; 011 gives no port and is flagged reserved
  function automatic logic [2:0] port_mask_f(input logic [2:0] code);
    case (code)
      3'h0: port_mask_f = 3'h1;
      3'h1: port_mask_f = 3'h2;
      3'h2: port_mask_f = 3'h4;
      3'h4: port_mask_f = 3'h3;
      3'h5: port_mask_f = 3'h5;
      3'h6: port_mask_f = 3'h6;
      3'h7: port_mask_f = 3'h7;
      default: port_mask_f = 3'h0;
    endcase
  endfunction

  // combine the fields; lower word holds the first 32 mac bits
  assign entry_o.mac = {upper_i.mac_hi, lower_i};
  assign entry_o.valid = upper_i.valid;
  assign entry_o.invalidate = ~upper_i.valid;
  assign entry_o.stat = upper_i.stat;
  assign entry_o.ageable = ~upper_i.stat;
  assign entry_o.override = upper_i.stat & upper_i.age_ovr;
  assign entry_o.filter = upper_i.filter;
  assign entry_o.prio_use = upper_i.prio_en & da_prio_i;
  assign entry_o.prio = upper_i.prio;
  assign entry_o.port_mask = port_mask_f(upper_i.port);
  assign entry_o.port_rsvd = (upper_i.port == 3'h3);

endmodule // lkw_entry_decode
`default_nettype wire

// ### design/lkw_entry_upper.sv
// upper staging word of the lookup table entry write path
`timescale 1ns/1ps
`default_nettype none
module lkw_entry_upper
  import lkw_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // internal register access from the serial management unit
  input wire logic [15:0] CSR_ADDR_I,
  input wire logic CSR_WR_I,
  input wire logic [31:0] CSR_WDATA_I,
  input wire logic CSR_RD_I,
  output logic [31:0] CSR_RDATA_O,
  output logic CSR_ACK_O,
  // commit request, lower staging word and global priority setting
  input wire logic COMMIT_I,
  input wire logic [31:0] LOWER_WORD_I,
  input wire logic DA_PRIO_I,
  // table write side
  input wire logic TBL_DONE_I,
  output logic TBL_WR_O,
  output lkw_entry_type TBL_ENTRY_O,
  output logic MAKE_PENDING_O
);

  lkw_upper_type upper_r;
  lkw_upper_type upper_nxt;
  lkw_entry_type entry_dec;
  logic [31:0] upper_word;
  logic hit;
  logic [31:0] rdata_nxt;
  logic pending_nxt;

  // address decode and read mux; reserved bits 31:27 read as zero
  assign hit = (CSR_ADDR_I == LKW_UPPER_OFS);
  assign upper_word = {5'h00, upper_r};
  assign rdata_nxt = (CSR_RD_I && hit) ? upper_word : LKW_RDATA_RST;
  // writes ignore the reserved bits; a commit never touches the store
  assign upper_nxt = (CSR_WR_I && hit) ? lkw_upper_type'(CSR_WDATA_I[26:0])
                                       : upper_r;
  // set wins over clear so a done in the commit cycle cannot lose it
  assign pending_nxt = COMMIT_I | (MAKE_PENDING_O & ~TBL_DONE_I);

  // field decoding kept apart so the table side sees one clean record
  lkw_entry_decode u_decode (
    .upper_i(upper_r),
    .lower_i(LOWER_WORD_I),
    .da_prio_i(DA_PRIO_I),
    .entry_o(entry_dec)
  );

  // staging store, cleared only by reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      upper_r <= lkw_upper_type'(LKW_UPPER_RST[26:0]);
    end else begin
      upper_r <= upper_nxt;
    end
  end

  // register read answer one cycle after the strobe
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      CSR_RDATA_O <= LKW_RDATA_RST;
      CSR_ACK_O <= 1'b0;
    end else begin
      CSR_RDATA_O <= rdata_nxt;
      CSR_ACK_O <= (CSR_RD_I | CSR_WR_I) & hit;
    end
  end

  // commit: both words go out together as one table write
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      TBL_WR_O <= 1'b0;
      TBL_ENTRY_O <= '0;
      MAKE_PENDING_O <= 1'b0;
    end else begin
      TBL_WR_O <= COMMIT_I;
      if (COMMIT_I) begin
        TBL_ENTRY_O <= entry_dec;
      end
      MAKE_PENDING_O <= pending_nxt;
    end
  end

  // checks
  AST_VALID_COMMIT: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I |=> TBL_WR_O && TBL_ENTRY_O.valid == $past(upper_r.valid)
      && TBL_ENTRY_O.invalidate != TBL_ENTRY_O.valid)
    else $error("valid flag not carried to the table");
  AST_OVERRIDE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TBL_WR_O |-> TBL_ENTRY_O.override
      == (TBL_ENTRY_O.stat && $past(upper_r.age_ovr)))
    else $error("override not static and age set");
  AST_STATIC_AGE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TBL_WR_O |-> TBL_ENTRY_O.ageable != TBL_ENTRY_O.stat)
    else $error("static entry marked ageable");
  AST_AGEABLE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I && !upper_r.stat |=> TBL_ENTRY_O.ageable)
    else $error("non-static entry not ageable");
  AST_FILTER: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I |=> TBL_ENTRY_O.filter == $past(upper_r.filter))
    else $error("filter flag lost");
  AST_PRIO_USE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I |=> TBL_ENTRY_O.prio_use
      == ($past(upper_r.prio_en) && $past(DA_PRIO_I)))
    else $error("priority use wrong");
  AST_PORT_MAP: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I && upper_r.port == 3'h7 ##1 1'b1 |-> TBL_ENTRY_O.port_mask == 3'h7
      && !TBL_ENTRY_O.port_rsvd)
    else $error("all-port code decoded wrong");
  AST_PORT_RSVD: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I && upper_r.port == 3'h3 |=> TBL_ENTRY_O.port_rsvd
      && TBL_ENTRY_O.port_mask == 3'h0)
    else $error("reserved port code not flagged");
  AST_MAC: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I |=> TBL_ENTRY_O.mac
      == {$past(upper_r.mac_hi), $past(LOWER_WORD_I)})
    else $error("mac bits misplaced");
  // the done pulse may come at any time after the commit, so only the
  // local step is checked: set by a commit, kept until done
  AST_PENDING: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I || (MAKE_PENDING_O && !TBL_DONE_I) |=> MAKE_PENDING_O)
    else $error("pending dropped before done");
  AST_PENDING_END: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    MAKE_PENDING_O && TBL_DONE_I && !COMMIT_I |=> !MAKE_PENDING_O)
    else $error("pending kept after done");
  AST_KEEP: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I && !(CSR_WR_I && hit) |=> upper_r == $past(upper_r))
    else $error("commit altered the staging word");
  AST_READ: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    CSR_RD_I && hit && !CSR_WR_I |=> CSR_ACK_O
      && CSR_RDATA_O == {5'h00, $past(upper_r)})
    else $error("read-back mismatch");

  // scenarios
  COV_COMMIT_STATIC: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I && upper_r.stat && upper_r.valid);
  COV_INVALIDATE: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    COMMIT_I && !upper_r.valid);
  COV_WRITE_THEN_COMMIT: cover property (@(posedge SYS_CLK_I)
    disable iff (RST_I) CSR_WR_I && hit ##1 COMMIT_I ##[1:4] TBL_DONE_I);

endmodule // lkw_entry_upper
`default_nettype wire

// ### shared/lkw_pkg.sv
// constants and types for the lookup entry upper staging word
// Overview of operation
// - valid set commits a valid entry; clear invalidates the matching prior entry
// - static with bit 25 set overrides port state, except disabled ports
// - static entries are never aged out nor changed by learning
// - non-static entries are removed after 5 to 10 minutes idle
// - filter flag discards frames whose destination matches the entry
// - priority field used only with entry enable and global setting both set
// - port field: single ports 0..2, 011 reserved, pairs, 111 all ports
// - low sixteen bits are the last MAC bits, bit 15 last on wire
// - upper 32-bit staging word consumed with the lower word at commit
// - commit writes both words into the table; a status flag shows completion
package lkw_pkg;

  // register number of the upper staging word
  localparam logic [15:0] LKW_UPPER_OFS = 16'h1802;

  // field positions
  localparam int LKW_VALID_BIT = 26;
  localparam int LKW_AGE_BIT = 25;
  localparam int LKW_STATIC_BIT = 24;
  localparam int LKW_FILTER_BIT = 23;
  localparam int LKW_PRIO_EN_BIT = 22;
  localparam int LKW_PRIO_LSB = 19;
  localparam int LKW_PORT_LSB = 16;
  localparam int LKW_MAC_LSB = 0;

  // reset values
  localparam logic [31:0] LKW_UPPER_RST = 32'h0000_0000;
  localparam logic [31:0] LKW_RDATA_RST = 32'h0000_0000;

  // inactivity interval bounds for non-static entries, in minutes
  localparam int LKW_AGE_MIN_MINUTES = 5;
  localparam int LKW_AGE_MAX_MINUTES = 10;

  // stored fields of the upper word, msb first as laid out in the register
  typedef struct packed {
    logic valid;
    logic age_ovr;
    logic stat;
    logic filter;
    logic prio_en;
    logic [2:0] prio;
    logic [2:0] port;
    logic [15:0] mac_hi;
  } lkw_upper_type;

  // attributes of one committed entry as handed to the table logic
  typedef struct packed {
    logic [47:0] mac;
    logic valid;
    logic invalidate;
    logic stat;
    logic ageable;
    logic override;
    logic filter;
    logic prio_use;
    logic [2:0] prio;
    logic [2:0] port_mask;
    logic port_rsvd;
  } lkw_entry_type;

endpackage

// ### sim/lkw_entry_upper_tb.sv
// self-checking testbench for the lookup entry upper staging word
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  error_cnt++; $display("Error at %0t: got %h exp %h", $time, got, exp); end end
module lkw_entry_upper_tb;
  import lkw_pkg::*;
  typedef struct packed {logic [31:0] w; logic [3:0] pm;} lkw_row_type;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, commit = 1'h0;
  logic da = 1'h0, done = 1'h0, ack, tbl_wr, pend;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, lower = 32'h0000_0000, rdata;
  lkw_entry_type entry;
  int error_cnt = 0, samples_checked = 0;
  // pm holds {reserved flag, port mask} expected for each port code;
  // rows with static clear always carry the age bit, as software must
  lkw_row_type rows [8] = '{'{32'hF500_1234, 4'h1}, '{32'h0381_ABCD, 4'h2},
    '{32'h067A_8001, 4'h4}, '{32'h0613_5555, 4'h8}, '{32'h02CC_FFFF, 4'h3},
    '{32'h0575_0000, 4'h5}, '{32'h0206_8000, 4'h6}, '{32'h07FF_7FFF, 4'h7}};

  lkw_entry_upper i_lkw_entry_upper (.SYS_CLK_I(clk), .RST_I(rst),
    .CSR_ADDR_I(addr), .CSR_WR_I(wr), .CSR_WDATA_I(wdata), .CSR_RD_I(rd),
    .CSR_RDATA_O(rdata), .CSR_ACK_O(ack), .COMMIT_I(commit),
    .LOWER_WORD_I(lower), .DA_PRIO_I(da), .TBL_DONE_I(done),
    .TBL_WR_O(tbl_wr), .TBL_ENTRY_O(entry), .MAKE_PENDING_O(pend));

  // 20 MHz clock
  always #25 clk = ~clk;

  // inputs move 2 ns after the edge so the design never races the bench
  task cyc;
    @(posedge clk);
    #2;
  endtask

  // entry expected from the staged word, worked out field by field
  function automatic lkw_entry_type exp_f(logic [31:0] w, logic [31:0] lo,
      logic d, logic [3:0] pm);
    lkw_entry_type e;
    e = '{mac: {w[15:0], lo}, valid: w[26], invalidate: ~w[26],
      stat: w[24], ageable: ~w[24], override: w[24] & w[25], filter: w[23],
      prio_use: w[22] & d, prio: w[21:19], port_mask: pm[2:0],
      port_rsvd: pm[3]};
    return e;
  endfunction

  task wr_reg(input logic [15:0] a, input logic [31:0] d, input logic hit);
    addr = a;
    wdata = d;
    wr = 1'h1;
    cyc;
    wr = 1'h0;
    `CHK(ack, hit)
  endtask

  task rd_chk(input logic [31:0] exp);
    addr = 16'h1802;
    rd = 1'h1;
    cyc;
    rd = 1'h0;
    `CHK(ack, 1'h1)
    `CHK(rdata, exp)
  endtask

  // commit, then let the table finish two cycles later
  task commit_chk(input logic [31:0] lo, input logic d,
      input lkw_entry_type exp);
    lower = lo;
    da = d;
    commit = 1'h1;
    cyc;
    commit = 1'h0;
    `CHK(tbl_wr, 1'h1)
    `CHK(entry, exp)
    cyc;
    `CHK(tbl_wr, 1'h0)
    `CHK(pend, 1'h1)
    done = 1'h1;
    cyc;
    done = 1'h0;
    `CHK(pend, 1'h0)
  endtask

  task stop_test;
    $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 200 cycles
  initial begin
    #(50 * 400);
    error_cnt++;
    stop_test;
  end

  // main sequence
  initial begin
    repeat (6) cyc;
    rst = 1'h0;
    `CHK(entry, lkw_entry_type'('0))
    rd_chk(32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      wr_reg(16'h1802, rows[i].w, 1'h1);
      rd_chk({5'h00, rows[i].w[26:0]});
      commit_chk(~rows[i].w, i[0], exp_f(rows[i].w, ~rows[i].w, i[0],
        rows[i].pm));
      rd_chk({5'h00, rows[i].w[26:0]});
    end
    // a neighbour's address must leave the word alone
    wr_reg(16'h1801, 32'h0000_0000, 1'h0);
    rd_chk(32'h07FF_7FFF);
    // write and commit together: the commit takes the old word
    addr = 16'h1802;
    wdata = 32'h0100_0000;
    wr = 1'h1;
    commit = 1'h1;
    lower = 32'h0000_0000;
    da = 1'h1;
    cyc;
    wr = 1'h0;
    commit = 1'h0;
    `CHK(entry, exp_f(32'h07FF_7FFF, 32'h0, 1'h1, 4'h7))
    `CHK(pend, 1'h1)
    // commit and done in one cycle: the new request keeps pending set
    commit = 1'h1;
    done = 1'h1;
    cyc;
    commit = 1'h0;
    `CHK(pend, 1'h1)
    cyc;
    done = 1'h0;
    `CHK(pend, 1'h0)
    rd_chk(32'h0100_0000);
    // reset in mid-run clears the word; an all-zero commit invalidates
    rst = 1'h1;
    repeat (2) cyc;
    rst = 1'h0;
    rd_chk(32'h0000_0000);
    commit_chk(32'h0, 1'h0, exp_f(32'h0, 32'h0, 1'h0, 4'h1));
    stop_test;
  end
endmodule // lkw_entry_upper_tb
`default_nettype wire
